/* File: design/scl_pkg.sv */
// Functional notes
// - Both rotary switches are sampled only at power-up; later changes are ignored.
// - Lower switch above 9 at power-up selects bit-rate selection from upper switch.
// - Upper positions 0 to 7 map to 10k,20k,50k,125k,250k,500k,800k,1M bit/s.
// - Bit rate lives in nonvolatile storage; unconfigured default is 1 Mbit/s.
// - Node address is never stored; it is derived anew at every power-up.
// - Node address equals ten times upper switch plus lower switch.
// - Decoded addresses 128 and 129 are invalid.
// - Decoded address zero is invalid; valid addresses are 1 to 127.
// - Bit-rate position or invalid address keeps the fieldbus silent.
// - Only a power cycle with valid switches enables communication after invalid start.
// - A bit-rate selection power-up yields no node address from the switches.
// - Each blink lasts 200 ms; sequences are separated by one second off.
// - Continuous blinking alternates 200 ms on and 200 ms off.
// - Blink-N gives N 200 ms pulses, 200 ms gaps, then one second off.
// - Stored bit rate is overwritten only when the selection has changed.
// - Error indicator blinks continuously when the switches hold an invalid address.
// - Run indicator: blinking pre-op, on operational, blink-1 stopped, off in reset.
package scl_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SCL_OFF_CONFIG = 8'h00;
	localparam logic [7:0] SCL_OFF_CTRL = 8'h04;
	localparam logic [7:0] SCL_OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] SCL_OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] SCL_OFF_NV_RATE = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SCL_CFG_ADDR_LSB = 0;
	localparam int SCL_CFG_RATE_LSB = 8;
	localparam int SCL_CFG_VALID_BIT = 12;
	localparam int SCL_CFG_RATESEL_BIT = 13;
	localparam int SCL_CFG_DONE_BIT = 14;
	localparam int SCL_CFG_UPPER_LSB = 16;
	localparam int SCL_CFG_LOWER_LSB = 20;
	localparam int SCL_CTRL_RUN_LSB = 0;
	localparam int SCL_CTRL_ERR_LSB = 2;
	localparam int SCL_CTRL_ERRN_LSB = 4;
	localparam int SCL_CTRL_ACT_LSB = 8;
	localparam int SCL_IRQ_DONE_BIT = 0;
	localparam int SCL_IRQ_INVALID_BIT = 1;
	localparam int SCL_IRQ_RATEWR_BIT = 2;

	// ----------------------------------------------------------------
	// Switch decoding and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] SCL_LOWER_MAX_DIGIT = 4'h9;
	localparam logic [3:0] SCL_UPPER_MAX_RATE_POS = 4'h7;
	localparam logic [7:0] SCL_ADDR_MAX = 8'h7F;
	localparam logic [7:0] SCL_ADDR_TEN = 8'h0A;
	localparam logic [2:0] SCL_RATE_DEFAULT = 3'h7;
	localparam logic [31:0] SCL_IRQ_MASK_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SCL_CLK_HZ = 40_000_000;
	localparam int SCL_BLINK_MS = 200;
	localparam int SCL_GAP_MS = 1000;
	localparam int SCL_BLINK_CYC = SCL_CLK_HZ / 1000 * SCL_BLINK_MS;
	localparam int SCL_GAP_SLOTS = SCL_GAP_MS / SCL_BLINK_MS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SCL_PAT_OFF = 2'b00,
		SCL_PAT_ON = 2'b01,
		SCL_PAT_BLINKING = 2'b10,
		SCL_PAT_BLINKN = 2'b11
	} scl_pat_t;

	typedef enum logic [1:0]
	{
		SCL_RUN_RESET = 2'b00,
		SCL_RUN_PREOP = 2'b01,
		SCL_RUN_OPER = 2'b10,
		SCL_RUN_STOPPED = 2'b11
	} scl_run_t;

	typedef enum logic [1:0]
	{
		SCL_ST_SAMPLE = 2'b00,
		SCL_ST_DONE = 2'b01
	} scl_state_t;

endpackage : scl_pkg

/* File: design/scl_top.sv */
// Our own choices: the AHB-Lite slave port and the register offsets.
module scl_top
	import scl_pkg::*;
#(
	parameter int BLINK_CYC = SCL_BLINK_CYC,
	parameter int NUM_LED = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] upper_switch,
	input wire logic [3:0] lower_switch,
	input wire logic [2:0] nv_rate_in,
	input wire logic nv_rate_valid,
	output logic nv_rate_write,
	output logic [2:0] nv_rate_out,
	output logic [6:0] node_address,
	output logic [2:0] bit_rate,
	output logic fieldbus_enable,
	output logic [NUM_LED-1:0] led,
	output logic irq
);

	// ----------------------------------------------------------------
	// Power-up sampling
	// ----------------------------------------------------------------
	function automatic logic [7:0] decode_addr(input logic [3:0] up, input logic [3:0] lo);
		decode_addr = 8'(up) * SCL_ADDR_TEN + 8'(lo);
	endfunction

	scl_state_t state_reg, state_next;
	logic [3:0] upper_reg, upper_next, lower_reg, lower_next;
	logic [6:0] addr_reg, addr_next;
	logic [2:0] rate_reg, rate_next;
	logic valid_reg, valid_next, ratesel_reg, ratesel_next;
	logic nvwr_reg, nvwr_next;
	logic ev_done, ev_invalid;
	logic [7:0] dec;

	always_comb
	begin
		state_next = state_reg;
		upper_next = upper_reg;
		lower_next = lower_reg;
		addr_next = addr_reg;
		rate_next = rate_reg;
		valid_next = valid_reg;
		ratesel_next = ratesel_reg;
		nvwr_next = 1'b0;
		ev_done = 1'b0;
		ev_invalid = 1'b0;
		dec = decode_addr(upper_switch, lower_switch);
		case (state_reg)
			SCL_ST_SAMPLE:
			begin
				// Switches are captured once, after reset release only
				upper_next = upper_switch;
				lower_next = lower_switch;
				state_next = SCL_ST_DONE;
				ev_done = 1'b1;
				rate_next = nv_rate_valid ? nv_rate_in : SCL_RATE_DEFAULT;
				if (lower_switch > SCL_LOWER_MAX_DIGIT)
				begin
					ratesel_next = 1'b1;
					valid_next = 1'b0;
					addr_next = 7'h00;
					ev_invalid = 1'b1;
					// Positions 8..15 keep the stored value
					if (upper_switch <= SCL_UPPER_MAX_RATE_POS)
					begin
						rate_next = upper_switch[2:0];
						// Only rewrite nonvolatile storage on a real change
						nvwr_next = !nv_rate_valid || (nv_rate_in != upper_switch[2:0]);
					end
				end
				else
				begin
					ratesel_next = 1'b0;
					// Address is never persisted, only derived here
					addr_next = dec[6:0];
					valid_next = (dec != 8'h00) && (dec <= SCL_ADDR_MAX);
					ev_invalid = !valid_next;
				end
			end
			SCL_ST_DONE:
			begin
				// Held until the next power-up; no re-sampling path exists
				state_next = SCL_ST_DONE;
			end
			default:
			begin
				state_next = SCL_ST_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= SCL_ST_SAMPLE;
			upper_reg <= 4'h0;
			lower_reg <= 4'h0;
			addr_reg <= 7'h00;
			rate_reg <= SCL_RATE_DEFAULT;
			valid_reg <= 1'b0;
			ratesel_reg <= 1'b0;
			nvwr_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			upper_reg <= upper_next;
			lower_reg <= lower_next;
			addr_reg <= addr_next;
			rate_reg <= rate_next;
			valid_reg <= valid_next;
			ratesel_reg <= ratesel_next;
			nvwr_reg <= nvwr_next;
		end
	end

	// ----------------------------------------------------------------
	// Sampled settings
	// ----------------------------------------------------------------
	assign node_address = addr_reg;
	assign bit_rate = rate_reg;
	assign nv_rate_write = nvwr_reg;
	assign nv_rate_out = rate_reg;
	assign fieldbus_enable = valid_reg && (state_reg == SCL_ST_DONE);

	// ----------------------------------------------------------------
	// Blink timebase: one pulse per 200 ms slot
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_reg, tick_cnt_next;
	logic tick;

	always_comb
	begin
		// One shared counter keeps all indicators in step with each other
		tick = (tick_cnt_reg == 32'(BLINK_CYC - 1));
		tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tick_cnt_reg <= 32'h0000_0000;
		else
			tick_cnt_reg <= tick_cnt_next;
	end

	// ----------------------------------------------------------------
	// Pattern generators, one per indicator
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg, ctrl_next;
	scl_pat_t pat [NUM_LED];
	logic [3:0] cnt [NUM_LED];

	always_comb
	begin
		for (int i = 0; i < NUM_LED; i++)
		begin
			pat[i] = SCL_PAT_OFF;
			cnt[i] = 4'h1;
		end
		// Indicator 5 (index 4): run state
		case (scl_run_t'(ctrl_reg[SCL_CTRL_RUN_LSB +: 2]))
			SCL_RUN_PREOP: pat[4] = SCL_PAT_BLINKING;
			SCL_RUN_OPER: pat[4] = SCL_PAT_ON;
			SCL_RUN_STOPPED: pat[4] = SCL_PAT_BLINKN;
			default: pat[4] = SCL_PAT_OFF;
		endcase
		// Indicator 4 (index 3): invalid address overrides software
		if (!valid_reg && (state_reg == SCL_ST_DONE))
			pat[3] = SCL_PAT_BLINKING;
		else
		begin
			pat[3] = scl_pat_t'(ctrl_reg[SCL_CTRL_ERR_LSB +: 2]);
			cnt[3] = ctrl_reg[SCL_CTRL_ERRN_LSB +: 4];
		end
		// Activity indicators 1,2,3,7 follow software; 6 (index 5) stays off
		pat[0] = ctrl_reg[SCL_CTRL_ACT_LSB] ? SCL_PAT_ON : SCL_PAT_OFF;
		pat[1] = ctrl_reg[SCL_CTRL_ACT_LSB + 1] ? SCL_PAT_ON : SCL_PAT_OFF;
		pat[2] = ctrl_reg[SCL_CTRL_ACT_LSB + 2] ? SCL_PAT_ON : SCL_PAT_OFF;
		pat[6] = ctrl_reg[SCL_CTRL_ACT_LSB + 3] ? SCL_PAT_ON : SCL_PAT_OFF;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_LED; g++)
		begin : g_led
			// Slot counter: N pulses with N-1 gaps, then five off slots of 200 ms
			// Six bits so that N = 15 (34 slots) does not wrap the sequence
			logic [5:0] slot_reg, slot_next;
			logic led_reg, led_next;
			logic [5:0] seq_len;
			always_comb
			begin
				// Last index: final pulse at slot 2N - 2, then five gap slots
				seq_len = 6'({cnt[g], 1'b0}) + 6'(SCL_GAP_SLOTS) - 6'h02;
				slot_next = slot_reg;
				led_next = led_reg;
				// Steady patterns follow a change at once instead of waiting for a slot
				if (pat[g] == SCL_PAT_ON)
					led_next = 1'b1;
				else if (pat[g] == SCL_PAT_OFF)
					led_next = 1'b0;
				if (tick)
				begin
					slot_next = (slot_reg >= seq_len) ? 6'h00 : slot_reg + 6'h01;
					case (pat[g])
						SCL_PAT_ON: led_next = 1'b1;
						SCL_PAT_BLINKING: led_next = !led_reg;
						// Even slots below 2N are on, odd ones and the gap off
						SCL_PAT_BLINKN: led_next = (slot_next < 6'({cnt[g], 1'b0}))
							&& !slot_next[0];
						default: led_next = 1'b0;
					endcase
				end
			end
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					slot_reg <= 6'h00;
					led_reg <= 1'b0;
				end
				else
				begin
					slot_reg <= slot_next;
					led_reg <= led_next;
				end
			end
			assign led[g] = led_reg;
		end
	endgenerate

	// ----------------------------------------------------------------
	// AHB-Lite slave and interrupts
	// ----------------------------------------------------------------
	logic wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
	logic [7:0] a_reg, a_next;
	logic [31:0] rdata_reg, rdata_next, stat_reg, stat_next, mask_reg, mask_next;
	logic [31:0] cfg_word;
	logic take;
	// Only whole words are served, so hsize is not looked at

	always_comb
	begin
		take = hsel && hready && htrans[1];
		cfg_word = 32'h0000_0000;
		cfg_word[SCL_CFG_ADDR_LSB +: 7] = addr_reg;
		cfg_word[SCL_CFG_RATE_LSB +: 3] = rate_reg;
		cfg_word[SCL_CFG_VALID_BIT] = valid_reg;
		cfg_word[SCL_CFG_RATESEL_BIT] = ratesel_reg;
		cfg_word[SCL_CFG_DONE_BIT] = (state_reg == SCL_ST_DONE);
		cfg_word[SCL_CFG_UPPER_LSB +: 4] = upper_reg;
		cfg_word[SCL_CFG_LOWER_LSB +: 4] = lower_reg;
		wr_pend_next = take && hwrite;
		rd_pend_next = take && !hwrite;
		a_next = take ? haddr[7:0] : a_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		rdata_next = rdata_reg;
		if (wr_pend_reg)
		begin
			if (a_reg == SCL_OFF_CTRL)
				ctrl_next = hwdata;
			else if (a_reg == SCL_OFF_IRQ_MASK)
				mask_next = hwdata;
		end
		// A read right behind a write to the same register sees the new word
		if (take && !hwrite)
		begin
			if (haddr[7:0] == SCL_OFF_CONFIG)
				rdata_next = cfg_word;
			else if (haddr[7:0] == SCL_OFF_CTRL)
				rdata_next = ctrl_next;
			else if (haddr[7:0] == SCL_OFF_IRQ_STAT)
				rdata_next = stat_reg;
			else if (haddr[7:0] == SCL_OFF_IRQ_MASK)
				rdata_next = mask_next;
			else if (haddr[7:0] == SCL_OFF_NV_RATE)
				rdata_next = {29'h0000_0000, nv_rate_in};
			else
				rdata_next = 32'h0000_0000;
		end
		// Read clears status; a same-cycle event still sets its bit
		if (rd_pend_reg && (a_reg == SCL_OFF_IRQ_STAT))
			stat_next = 32'h0000_0000;
		if (ev_done)
			stat_next[SCL_IRQ_DONE_BIT] = 1'b1;
		if (ev_invalid)
			stat_next[SCL_IRQ_INVALID_BIT] = 1'b1;
		if (nvwr_next)
			stat_next[SCL_IRQ_RATEWR_BIT] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			a_reg <= 8'h00;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg <= 32'h0000_0000;
			stat_reg <= 32'h0000_0000;
			mask_reg <= SCL_IRQ_MASK_RESET;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			a_reg <= a_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
		end
	end

	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	assign irq = |(stat_reg & mask_reg);

endmodule // scl_top

/* File: sim/scl_nv_model.sv */
module scl_nv_model
(
	input wire logic hclk,
	input wire logic nv_rate_write,
	input wire logic [2:0] nv_rate_out,
	output logic [2:0] nv_rate_in,
	output logic nv_rate_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	// Never reset: contents must outlive every power cycle
	// Unconfigured cells read as junk, so the block must fall back on its default
	initial nv_rate_valid = 1'b0;
	initial nv_rate_in = 3'h2;
	always @(posedge hclk)
		if (nv_rate_write)
		begin
			nv_rate_in <= nv_rate_out;
			nv_rate_valid <= 1'b1;
		end
endmodule // scl_nv_model

/* File: sim/scl_top_monitor.sv */
module scl_top_monitor
	import scl_pkg::*;
#(
	parameter int NUM_LED = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] upper_switch,
	input wire logic [3:0] lower_switch,
	input wire logic [2:0] nv_rate_in,
	input wire logic nv_rate_valid,
	input wire logic nv_rate_write,
	input wire logic [2:0] nv_rate_out,
	input wire logic [6:0] node_address,
	input wire logic [2:0] bit_rate,
	input wire logic fieldbus_enable,
	input wire logic [NUM_LED-1:0] led
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] cyc_reg;
	logic [7:0] sw_addr;
	logic [2:0] kept;
	logic s0, sel;
	// Switches only count at the first edge after reset release
	// Reset level is part of it, so the release edge itself never starts an attempt
	assign s0 = hresetn && cyc_reg == 2'h0;
	assign sel = lower_switch > 4'h9;
	assign sw_addr = 8'(upper_switch) * 8'h0A + 8'(lower_switch);
	assign kept = nv_rate_valid ? nv_rate_in : SCL_RATE_DEFAULT;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cyc_reg <= 2'h0;
		else if (cyc_reg != 2'h3)
			cyc_reg <= cyc_reg + 2'h1;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	addr_decode_a: assert property (s0 && !sel && sw_addr < 8'h80 |=>
		{1'b0, node_address} == $past(sw_addr))
		else $error("node address decode wrong");
	enable_valid_a: assert property (s0 && !sel |=>
		fieldbus_enable == ($past(sw_addr) != 8'h00 && $past(sw_addr) < 8'h80))
		else $error("fieldbus enable wrong for address");
	rate_pick_a: assert property (s0 && sel && !upper_switch[3] |=>
		4'(bit_rate) == $past(upper_switch))
		else $error("selected bit rate wrong");
	rate_noaddr_a: assert property (s0 && sel |=>
		node_address == 7'h00 && !fieldbus_enable)
		else $error("address taken in rate selection");
	rate_keep_a: assert property (s0 && (!sel || upper_switch[3]) |=>
		bit_rate == $past(kept) && !nv_rate_write)
		else $error("stored bit rate not kept");
	nv_once_a: assert property (nv_rate_write |->
		cyc_reg == 2'h1 && nv_rate_out == bit_rate)
		else $error("storage write outside power-up");
	hold_a: assert property (cyc_reg == 2'h3 |-> $stable(node_address) &&
		$stable(bit_rate) && $stable(fieldbus_enable))
		else $error("settings changed while running");
	led_unused_a: assert property (!led[5])
		else $error("unused indicator lit");
endmodule // scl_top_monitor
bind scl_top scl_top_monitor #(.NUM_LED(NUM_LED)) scl_top_monitor_inst (.hclk(hclk),
	.hresetn(hresetn), .upper_switch(upper_switch), .lower_switch(lower_switch),
	.nv_rate_in(nv_rate_in), .nv_rate_valid(nv_rate_valid), .nv_rate_write(nv_rate_write),
	.nv_rate_out(nv_rate_out), .node_address(node_address), .bit_rate(bit_rate),
	.fieldbus_enable(fieldbus_enable), .led(led));

/* File: sim/test_switch_config_and_led_blinker.sv */
module test_switch_config_and_led_blinker
	import scl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BC = 10;
	localparam logic [7:0] CS [9] = '{8'h34, 8'hC7, 8'hC8, 8'hC9, 8'h00, 8'h3A, 8'h3F,
		8'h9B, 8'h5C};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [3:0] up = 4'h0, lo = 4'h0;
	logic hreadyout, hresp, nv_rate_write, nv_rate_valid, fieldbus_enable, irq;
	logic [2:0] nv_rate_out, nv_rate_in, bit_rate, st = 3'h7;
	logic [6:0] node_address, led;
	logic stv = 1'b0, rd_dp = 1'b0;
	logic [31:0] exp_q[$];
	int miscompares = 0, checks_done = 0, nvw = 0;
	integer seed = 32'h0000_3e08;
	always #12.5 hclk = ~hclk;
	scl_top #(.BLINK_CYC(BC)) scl_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.upper_switch(up), .lower_switch(lo), .nv_rate_in(nv_rate_in),
		.nv_rate_valid(nv_rate_valid), .nv_rate_write(nv_rate_write),
		.nv_rate_out(nv_rate_out), .node_address(node_address), .bit_rate(bit_rate),
		.fieldbus_enable(fieldbus_enable), .led(led), .irq(irq));
	scl_nv_model scl_nv_model_inst (.hclk(hclk), .nv_rate_write(nv_rate_write),
		.nv_rate_out(nv_rate_out), .nv_rate_in(nv_rate_in), .nv_rate_valid(nv_rate_valid));
	task automatic tally_and_finish(bit to);
		if (to)
			miscompares++;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// --------------------------------
	// Bus master
	// --------------------------------
	task automatic wrdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge hclk);
		end
		if (n == 50)
			tally_and_finish(1);
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, '0);
	endtask
	// Read data is judged here, apart from the driver, at the data-phase edge
	always @(posedge hclk)
	begin
		if (nv_rate_write === 1'b1)
			nvw++;
		if (rd_dp && hreadyout === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("unexpected read", 0, 1);
			else
				chk("hrdata", exp_q.pop_front(), hrdata);
		end
		if (hreadyout === 1'b1)
			rd_dp <= hsel && htrans[1] && !hwrite;
	end
	// --------------------------------
	// Power cycle with full expectation
	// --------------------------------
	task automatic pw(logic [3:0] u, logic [3:0] l);
		logic s, ok, w;
		logic [7:0] a;
		int w0;
		s = l > 4'h9;
		a = s ? 8'h00 : 8'(u) * 8'h0A + 8'(l);
		ok = !s && a != 8'h00 && a < 8'h80;
		w = s && !u[3] && (!stv || st != u[2:0]);
		if (w)
			st = u[2:0];
		stv = stv | w;
		w0 = nvw;
		hresetn <= 1'b0;
		up <= u;
		lo <= l;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("irq masked", 0, irq);
		chk("fieldbus_enable", ok, fieldbus_enable);
		chk("bit_rate", st, bit_rate);
		chk("nv writes", w0 + w, nvw);
		chk("hresp", 0, hresp);
		if (a < 8'h80)
		begin
			chk("node_address", a, node_address);
			rd(SCL_OFF_CONFIG, {8'h00, l, u, 2'b01, s, ok, 1'b0, st, 1'b0, a[6:0]});
			bus(1'b1, SCL_OFF_CONFIG, $random(seed));
			rd(SCL_OFF_CONFIG, {8'h00, l, u, 2'b01, s, ok, 1'b0, st, 1'b0, a[6:0]});
		end
		bus(1'b1, SCL_OFF_IRQ_MASK, 32'h0000_0007);
		repeat (2) @(posedge hclk);
		chk("irq raised", 1, irq);
		rd(SCL_OFF_IRQ_STAT, {29'h0, w, !ok, 1'b1});
		repeat (2) @(posedge hclk);
		chk("irq cleared", 0, irq);
	endtask
	task automatic run_len(int i, logic v, output int n);
		n = 0;
		while (led[i] === v && n < 500)
		begin
			n++;
			@(posedge hclk);
		end
		if (n == 500)
			tally_and_finish(1);
	endtask
	task automatic meas(int i, output int off);
		int n;
		run_len(i, 1'b1, n);
		run_len(i, 1'b0, n);
		run_len(i, 1'b1, n);
		chk("led on time", BC, n);
		run_len(i, 1'b0, off);
	endtask
	task automatic ctl(logic [31:0] v);
		bus(1'b1, SCL_OFF_CTRL, v);
		repeat (2) @(posedge hclk);
	endtask
	initial
	begin
		int off, off2;
		foreach (CS[i])
			pw(CS[i][7:4], CS[i][3:0]);
		for (int u = 0; u < 8; u++)
			pw(4'(u), 4'hA + 4'($unsigned($random(seed)) % 6));
		repeat (4)
			pw(4'($unsigned($random(seed)) % 13), 4'($unsigned($random(seed)) % 10));
		pw(4'hC, 4'h8);
		meas(3, off);
		chk("err blinking off", BC, off);
		up <= 4'h2;
		lo <= 4'h5;
		repeat (20) @(posedge hclk);
		chk("enable after switch change", 0, fieldbus_enable);
		pw(4'h2, 4'h5);
		ctl(32'h0000_0A01);
		chk("activity leds", 7'h42, led & 7'h67);
		meas(4, off);
		chk("run blinking off", BC, off);
		ctl(32'h0000_0003);
		meas(4, off);
		chk("blink1 off", 5 * BC, off);
		ctl(32'h0000_002E);
		chk("run on", 1, led[4]);
		meas(3, off);
		// The next pulse is the other one of the pair, so its gap differs
		run_len(3, 1'b1, off2);
		chk("led on time", BC, off2);
		run_len(3, 1'b0, off2);
		chk("blink2 gaps", 6 * BC, off + off2);
		chk("run still on", 1, led[4]);
		rd(SCL_OFF_CTRL, 32'h0000_002E);
		ctl(32'h0000_0004);
		repeat (3 * BC) @(posedge hclk);
		chk("run off in reset", 0, led[4]);
		chk("err steady on", 1, led[3]);
		bus(1'b1, 8'h20, $random(seed));
		rd(8'h20, 32'h0000_0000);
		rd(SCL_OFF_IRQ_MASK, 32'h0000_0007);
		rd(SCL_OFF_NV_RATE, {29'h0, st});
		repeat (2) @(posedge hclk);
		chk("reads pending", 0, exp_q.size());
		tally_and_finish(0);
	end
endmodule // test_switch_config_and_led_blinker
